/* logic/cpid_pkg.sv */
`default_nettype none

package cpid_pkg;

    // ------------------------------------------------------------
    // Interface register word indices (chosen), byte address = 4 * index
    // ------------------------------------------------------------
    localparam logic [4:0] ADDR_RESPONSE  = 5'h00;
    localparam logic [4:0] ADDR_COMMAND   = 5'h01;
    localparam logic [4:0] ADDR_CONDITION = 5'h02;
    localparam logic [4:0] ADDR_SAVE      = 5'h03;
    localparam logic [4:0] ADDR_RESTORE   = 5'h04;
    localparam logic [4:0] ADDR_INSTADDR  = 5'h05;
    localparam logic [4:0] ADDR_CONTROL   = 5'h06;
    localparam logic [4:0] ADDR_STATUS    = 5'h07;

    // ------------------------------------------------------------
    // Operation word fields
    // ------------------------------------------------------------
    localparam int          OPW_LINE_MSB   = 15;
    localparam int          OPW_LINE_LSB   = 12;
    localparam logic [3:0]  OPW_LINE_CODE  = 4'hF;
    localparam int          OPW_SEL_MSB    = 11;
    localparam int          OPW_SEL_LSB    = 9;
    localparam logic [2:0]  SEL_DEFAULT    = 3'h1;
    localparam logic [2:0]  SEL_USER_LO    = 3'h6;
    localparam int          INSTR_MAX_WORDS = 8;
    localparam int          EXT_MAX_WORDS  = 6;

    // ------------------------------------------------------------
    // Response primitive fields
    // ------------------------------------------------------------
    localparam int          PRIM_COME_AGAIN = 15;
    localparam int          PRIM_PASS_PC    = 14;
    localparam int          PRIM_DIRECTION  = 13;
    localparam int          PRIM_INT_ALLOW  = 8;
    localparam int          PRIM_IDLE       = 1;
    localparam int          PRIM_COND       = 0;
    localparam logic [15:0] PRIM_NULL_BASE  = 16'h0800;
    localparam logic [15:0] PRIM_EXCEPTION  = 16'h1C00;
    localparam logic [15:0] PRIM_PROTOCOL   = 16'h1C00;
    localparam logic [7:0]  VEC_PROTOCOL    = 8'h0D;
    localparam logic [7:0]  VEC_UNORDERED   = 8'h30;
    localparam int          PRIM_TYPES_USED = 6;

    // ------------------------------------------------------------
    // Control register bits
    // ------------------------------------------------------------
    localparam int          CTL_PIPELINED   = 0;
    localparam int          CTL_EXC_ENABLE  = 1;
    localparam int          CTL_UNORD_TRAP  = 2;
    localparam int          CTL_SEL_LSB     = 4;
    localparam logic [15:0] CTL_RESET       = 16'h0012;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int          CLK_MHZ         = 125;
    localparam int          EXEC_NS         = 80;
    localparam int          EXEC_CYCLES     = (EXEC_NS * CLK_MHZ) / 1000;
    localparam logic [15:0] READ_ONES       = 16'hFFFF;

    // Dialog states
    typedef enum logic [3:0]
    {
        ST_IDLE = 4'b0001,
        ST_PCWT = 4'b0010,
        ST_BUSY = 4'b0100,
        ST_EXC  = 4'b1000
    } cpid_state_t;

endpackage : cpid_pkg

`default_nettype wire

/* logic/cpid_dialog.sv */
`timescale 1ns/1ns
`default_nettype none

module cpid_dialog
#(
    parameter int EXEC_CNT = cpid_pkg::EXEC_CYCLES
)
(
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic [4:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [31:0] rdata,
    output logic      [31:0] fault_addr,
    output logic             busy,
    output logic             protocol_err
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    cpid_pkg::cpid_state_t state_q;
    logic [15:0] prim_q;
    logic [15:0] ctl_q;
    logic [15:0] cmd_q;
    logic [31:0] iaddr_q;
    logic [7:0]  cnt_q;
    logic        pc_asked_q;
    logic        pc_got_q;
    logic        cond_q;
    logic        err_q;
    logic [31:0] rdata_q;

    logic        wr_cmd;
    logic        wr_cond;
    logic        wr_rest;
    logic        wr_ia;
    logic        rd_save;
    logic        rd_resp;
    logic        pipelined;
    logic        exc_en;
    logic [15:0] null_idle;
    logic [15:0] null_busy;
    logic [2:0]  sel_code;
    logic        sel_user;

    assign wr_cmd    = wr && (addr == cpid_pkg::ADDR_COMMAND);
    assign wr_cond   = wr && (addr == cpid_pkg::ADDR_CONDITION);
    assign wr_rest   = wr && (addr == cpid_pkg::ADDR_RESTORE);
    assign wr_ia     = wr && (addr == cpid_pkg::ADDR_INSTADDR);
    assign rd_save   = rd && (addr == cpid_pkg::ADDR_SAVE);
    assign rd_resp   = rd && (addr == cpid_pkg::ADDR_RESPONSE);
    assign pipelined = ctl_q[cpid_pkg::CTL_PIPELINED];
    assign exc_en    = ctl_q[cpid_pkg::CTL_EXC_ENABLE];
    // Select code this coprocessor answers to, and whether it is a user code
    assign sel_code  = ctl_q[cpid_pkg::CTL_SEL_LSB +: 3];
    assign sel_user  = (sel_code >= cpid_pkg::SEL_USER_LO);

    // Null primitive encodings built from fixed field positions
    always_comb
    begin
        null_idle = cpid_pkg::PRIM_NULL_BASE;
        null_idle[cpid_pkg::PRIM_IDLE] = 1'b1;
        null_busy = cpid_pkg::PRIM_NULL_BASE;
        null_busy[cpid_pkg::PRIM_INT_ALLOW]  = 1'b1;
        null_busy[cpid_pkg::PRIM_COME_AGAIN] = 1'b1;
        null_busy[cpid_pkg::PRIM_DIRECTION]  = 1'b0;
    end

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            ctl_q <= cpid_pkg::CTL_RESET;
        else if (wr && (addr == cpid_pkg::ADDR_CONTROL))
            ctl_q <= wdata[15:0];
    end

    // Instruction address register, write-only to the host
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            iaddr_q <= 32'h0000_0000;
        else if (wr_ia)
            iaddr_q <= wdata;
    end

    // ------------------------------------------------------------
    // Dialog state machine and response primitive
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_q    <= cpid_pkg::ST_IDLE;
            prim_q     <= 16'h0802;
            cmd_q      <= 16'h0000;
            cnt_q      <= 8'h00;
            pc_asked_q <= 1'b0;
            pc_got_q   <= 1'b0;
            cond_q     <= 1'b0;
            err_q      <= 1'b0;
        end
        else
        begin
            if (wr_ia)
                pc_got_q <= 1'b1;
            case (state_q)
                cpid_pkg::ST_IDLE:
                begin
                    if (wr_cmd)
                    begin
                        // Dialog begins with the command word; extension words stay with the host
                        cmd_q      <= wdata[15:0];
                        pc_got_q   <= 1'b0;
                        cnt_q      <= 8'(EXEC_CNT);
                        pc_asked_q <= exc_en;
                        prim_q     <= null_busy;
                        prim_q[cpid_pkg::PRIM_PASS_PC] <= exc_en;
                        state_q    <= exc_en ? cpid_pkg::ST_PCWT : cpid_pkg::ST_BUSY;
                    end
                    else if (wr_cond)
                    begin
                        // Condition evaluated at once, answer with null primitive unless the unordered trap fires
                        cond_q <= ^wdata[5:0];
                        if (ctl_q[cpid_pkg::CTL_UNORD_TRAP] && wdata[4])
                        begin
                            prim_q  <= cpid_pkg::PRIM_EXCEPTION | 16'(cpid_pkg::VEC_UNORDERED);
                            prim_q[cpid_pkg::PRIM_PASS_PC]    <= 1'b1;
                            prim_q[cpid_pkg::PRIM_COME_AGAIN] <= 1'b1;
                            state_q <= cpid_pkg::ST_EXC;
                        end
                        else
                        begin
                            prim_q <= cpid_pkg::PRIM_NULL_BASE;
                            prim_q[cpid_pkg::PRIM_COND] <= ^wdata[5:0];
                        end
                    end
                    else if (rd_save || wr_rest)
                    begin
                        // Save begins with a read; context moves are instant here
                        prim_q <= null_idle;
                    end
                end
                cpid_pkg::ST_PCWT:
                begin
                    // A new command or predicate in the initial phase is a violation
                    if (wr_cmd || wr_cond)
                        err_q <= 1'b1;
                    // First poll after a pass-PC request clears the bit
                    if (rd_resp)
                    begin
                        prim_q[cpid_pkg::PRIM_PASS_PC] <= 1'b0;
                        state_q <= cpid_pkg::ST_BUSY;
                    end
                end
                cpid_pkg::ST_BUSY:
                begin
                    if (cnt_q != 8'h00)
                        cnt_q <= cnt_q - 8'h01;
                    if (wr_cmd || wr_cond)
                        err_q <= 1'b1;
                    // Protocol fault when pipelined and the address never came
                    if (pipelined && pc_asked_q && !pc_got_q && !wr_ia && (cnt_q == 8'h00))
                    begin
                        prim_q  <= cpid_pkg::PRIM_PROTOCOL | 16'(cpid_pkg::VEC_PROTOCOL);
                        prim_q[cpid_pkg::PRIM_COME_AGAIN] <= 1'b1;
                        err_q   <= 1'b1;
                        state_q <= cpid_pkg::ST_EXC;
                    end
                    else if (cnt_q == 8'h00)
                    begin
                        prim_q  <= null_idle;
                        state_q <= cpid_pkg::ST_IDLE;
                    end
                end
                cpid_pkg::ST_EXC:
                begin
                    // Exception primitive held until the host reads it
                    if (rd_resp)
                    begin
                        prim_q  <= null_idle;
                        state_q <= cpid_pkg::ST_IDLE;
                    end
                end
                default:
                    state_q <= cpid_pkg::ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Read data, one cycle after the strobe
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            rdata_q <= 32'h0000_0000;
        else if (rd)
        begin
            if (addr == cpid_pkg::ADDR_RESPONSE)
                rdata_q <= {16'h0000, prim_q};
            else if (addr == cpid_pkg::ADDR_CONTROL)
                rdata_q <= {16'h0000, ctl_q};
            else if (addr == cpid_pkg::ADDR_STATUS)
                rdata_q <= {16'h0000, cmd_q[15:8], sel_user, sel_code, cond_q, err_q,
                            state_q[2:1] != 2'b00,
                            pc_got_q};
            else if (addr == cpid_pkg::ADDR_SAVE)
                rdata_q <= {16'h0000, null_idle};
            else
                rdata_q <= {16'h0000, cpid_pkg::READ_ONES};
        end
    end

    assign rdata        = rdata_q;
    assign fault_addr   = iaddr_q;
    assign busy         = (state_q != cpid_pkg::ST_IDLE);
    assign protocol_err = err_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence cmd_seen_s;
        (state_q == cpid_pkg::ST_IDLE) && wr_cmd;
    endsequence

    sequence busy_prim_s;
        prim_q[cpid_pkg::PRIM_COME_AGAIN] && prim_q[cpid_pkg::PRIM_INT_ALLOW];
    endsequence

    cmd_answer_a: assert property (@(posedge clk) disable iff (!reset_n)
        cmd_seen_s |=> busy_prim_s)
        else $error("command not answered by busy primitive");

    pc_first_a: assert property (@(posedge clk) disable iff (!reset_n)
        cmd_seen_s and exc_en |=> prim_q[cpid_pkg::PRIM_PASS_PC])
        else $error("pass-pc missing in first primitive");

    pc_once_a: assert property (@(posedge clk) disable iff (!reset_n)
        (state_q == cpid_pkg::ST_PCWT) && rd_resp |=> !prim_q[cpid_pkg::PRIM_PASS_PC])
        else $error("pass-pc repeated");

    stable_prim_a: assert property (@(posedge clk) disable iff (!reset_n)
        (state_q == cpid_pkg::ST_EXC) && !rd_resp |=> $stable(prim_q))
        else $error("primitive changed while pending");

    idle_flag_a: assert property (@(posedge clk) disable iff (!reset_n)
        (state_q == cpid_pkg::ST_IDLE) && ($past(state_q) == cpid_pkg::ST_BUSY)
        |-> prim_q[cpid_pkg::PRIM_IDLE])
        else $error("idle flag not set on completion");

    resp_read_a: assert property (@(posedge clk) disable iff (!reset_n)
        rd_resp |=> rdata == {16'h0000, $past(prim_q)})
        else $error("response read mismatch");

    ia_write_a: assert property (@(posedge clk) disable iff (!reset_n)
        wr_ia |=> fault_addr == $past(wdata))
        else $error("instruction address not stored");

    dir_zero_a: assert property (@(posedge clk) disable iff (!reset_n)
        (state_q == cpid_pkg::ST_BUSY) |-> !prim_q[cpid_pkg::PRIM_DIRECTION])
        else $error("direction set on null primitive");

    cond_ans_a: assert property (@(posedge clk) disable iff (!reset_n)
        (state_q == cpid_pkg::ST_IDLE) && wr_cond && !ctl_q[cpid_pkg::CTL_UNORD_TRAP]
        |=> prim_q[cpid_pkg::PRIM_COND] == ^($past(wdata) & 32'h0000_003F))
        else $error("condition result wrong");

    prim_kind_a: assert property (@(posedge clk) disable iff (!reset_n)
        (prim_q[12:9] == cpid_pkg::PRIM_NULL_BASE[12:9])
        || (prim_q[12:8] == cpid_pkg::PRIM_EXCEPTION[12:8]))
        else $error("primitive type outside the issued set");

endmodule : cpid_dialog

`default_nettype wire

/* tb/cpid_host_model.sv */
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------------------------------
// Host side of the interface register window
// ----------------------------------------------------------------
module cpid_host_model
(
    input  wire logic        clk,
    output logic      [4:0]  addr,
    output logic      [31:0] wdata,
    output logic             wr,
    output logic             rd,
    input  wire logic [31:0] rdata
);
    // Idle bus at time zero
    initial
    begin
        addr  = 5'h1F;
        wdata = 32'h0000_0000;
        wr    = 1'b0;
        rd    = 1'b0;
    end

    // One write cycle; released lines show a changed pattern
    task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
        wdata <= ~d;
        addr  <= ~a;
    endtask : wr_reg

    // One read cycle; data taken in the cycle after the strobe
    task automatic rd_reg(input logic [4:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        addr <= ~a;
        #1;
        d = rdata;
    endtask : rd_reg

    // Re-read the response while it asks to come again and is busy
    task automatic poll(output logic [31:0] d);
        int n;
        n = 0;
        d = 32'h0000_8900;
        while (d === 32'h0000_8900 && n < 20)
        begin
            rd_reg(cpid_pkg::ADDR_RESPONSE, d);
            n++;
        end
    endtask : poll

    // General type code, a plain default of the host's type decoder
    localparam logic [2:0] TYPE_GENERAL = 3'h0;

    // Start a general dialog only for a line-F word that carries the default select code
    task automatic issue(input logic [15:0] opw, input logic [15:0] cw);
        if (opw[15:12] == cpid_pkg::OPW_LINE_CODE && opw[11:9] == cpid_pkg::SEL_DEFAULT
            && opw[8:6] == TYPE_GENERAL)
            wr_reg(cpid_pkg::ADDR_COMMAND, {16'h0000, cw});
    endtask : issue
endmodule : cpid_host_model

`default_nettype wire

/* tb/coprocessor_instruction_dialog_tb.sv */
`timescale 1ns/1ns
`default_nettype none

module coprocessor_instruction_dialog_tb;
    localparam int EXEC_CNT = 10;

    logic        clk;
    logic        reset_n;
    logic [4:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
    logic [31:0] rdata;
    logic [31:0] fault_addr;
    logic        busy;
    logic        protocol_err;
    int          errors;
    int          tests_run;
    logic [31:0] d;
    logic [31:0] v;
    logic [31:0] ctl_tab [3] = '{32'h0000_0012, 32'h0000_0010, 32'h0000_0013};

    cpid_dialog #(.EXEC_CNT(EXEC_CNT)) cpid_dialog_i
    (
        .clk          (clk),
        .reset_n      (reset_n),
        .addr         (addr),
        .wdata        (wdata),
        .wr           (wr),
        .rd           (rd),
        .rdata        (rdata),
        .fault_addr   (fault_addr),
        .busy         (busy),
        .protocol_err (protocol_err)
    );

    cpid_host_model h
    (
        .clk   (clk),
        .addr  (addr),
        .wdata (wdata),
        .wr    (wr),
        .rd    (rd),
        .rdata (rdata)
    );

    // ----------------------------------------------------------------
    // Clock, checks and closing
    // ----------------------------------------------------------------
    initial clk = 1'b0;
    always #4 clk = ~clk;

    // Compare one value and count it
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // Condition answer in idle: null primitive with parity as result
    function automatic logic [31:0] cond_prim(input logic [31:0] p);
        return 32'h0000_0800 | {31'h0, ^p[5:0]};
    endfunction : cond_prim

    // Reset held for 16 cycles
    task automatic do_reset;
        @(posedge clk);
        reset_n <= 1'b0;
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
    endtask : do_reset

    task automatic tally_and_finish;
        $display("Comparisons %0d, mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : tally_and_finish

    // Watchdog cuts a hang short
    initial
    begin
        #200000;
        errors++;
        tally_and_finish();
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        errors    = 0;
        tests_run = 0;
        reset_n   = 1'b0;
        void'($urandom(32'hD441C2D1));
        do_reset();
        #1;
        check("rdata", rdata, 32'h0);
        check("fault_addr", fault_addr, 32'h0);
        check("busy", {31'h0, busy}, 32'h0);
        h.rd_reg(cpid_pkg::ADDR_RESPONSE, d);
        check("idle response", d, 32'h0000_0802);
        h.rd_reg(5'h1F, d);
        check("unmapped", d, 32'h0000_FFFF);
        h.rd_reg(cpid_pkg::ADDR_STATUS, d);
        check("reset status", d, 32'h0000_0010);
        h.rd_reg(cpid_pkg::ADDR_SAVE, d);
        check("save format", d, 32'h0000_0802);
        h.wr_reg(cpid_pkg::ADDR_RESTORE, $urandom);
        h.rd_reg(cpid_pkg::ADDR_RESPONSE, d);
        check("restore answer", d, 32'h0000_0802);
        h.wr_reg(cpid_pkg::ADDR_RESPONSE, $urandom);
        h.rd_reg(cpid_pkg::ADDR_RESPONSE, d);
        check("response write", d, 32'h0000_0802);
        $display("test reset done");
        // Random predicates evaluated in idle
        repeat (8)
        begin
            v = $urandom & 32'h0000_FFFF;
            h.wr_reg(cpid_pkg::ADDR_CONDITION, v);
            h.rd_reg(cpid_pkg::ADDR_RESPONSE, d);
            check("condition", d, cond_prim(v));
        end
        // Unordered trap: exception primitive, then idle
        h.wr_reg(cpid_pkg::ADDR_CONTROL, 32'h0000_0016);
        h.wr_reg(cpid_pkg::ADDR_CONDITION, 32'h0000_0010);
        h.rd_reg(cpid_pkg::ADDR_RESPONSE, d);
        check("trap", d, 32'h0000_DC30);
        h.rd_reg(cpid_pkg::ADDR_RESPONSE, d);
        check("after trap", d, 32'h0000_0802);
        h.wr_reg(cpid_pkg::ADDR_CONTROL, 32'h0000_0060);
        h.rd_reg(cpid_pkg::ADDR_STATUS, d);
        check("user select", d, 32'h0000_00E8);
        $display("test condition done");
        // Pipelined dialog with the address passed
        h.wr_reg(cpid_pkg::ADDR_CONTROL, 32'h0000_0013);
        h.issue(16'hF200 | 16'($urandom & 32'h0000_003F), 16'($urandom));
        #1;
        check("busy", {31'h0, busy}, 32'h1);
        h.rd_reg(cpid_pkg::ADDR_RESPONSE, d);
        check("first primitive", d, 32'h0000_C900);
        v = $urandom;
        h.wr_reg(cpid_pkg::ADDR_INSTADDR, v);
        #1;
        check("fault_addr", fault_addr, v);
        h.rd_reg(cpid_pkg::ADDR_RESPONSE, d);
        check("second primitive", d, 32'h0000_8900);
        h.poll(d);
        check("done primitive", d, 32'h0000_0802);
        check("violation", {31'h0, protocol_err}, 32'h0);
        $display("test address pass done");
        // Address never passed, under each of the three control settings in ctl_tab
        foreach (ctl_tab[i])
        begin
            h.wr_reg(cpid_pkg::ADDR_CONTROL, ctl_tab[i]);
            h.issue(16'hF200 | 16'($urandom & 32'h0000_003F), 16'($urandom));
            h.rd_reg(cpid_pkg::ADDR_RESPONSE, d);
            check("first primitive", d, ctl_tab[i][1] ? 32'h0000_C900 : 32'h0000_8900);
            h.poll(d);
            check("end primitive", d, (ctl_tab[i][1:0] == 2'b11) ? 32'h0000_9C0D : 32'h0000_0802);
            check("violation", {31'h0, protocol_err}, {31'h0, ctl_tab[i][1:0] == 2'b11});
        end
        $display("test skipped address done");
        do_reset();
        #1;
        check("violation cleared", {31'h0, protocol_err}, 32'h0);
        $display("test second reset done");
        // Command issued while the previous one still runs
        v = $urandom;
        h.issue(16'hF200, v[15:0]);
        h.rd_reg(cpid_pkg::ADDR_RESPONSE, d);
        check("reset control", d, 32'h0000_C900);
        h.issue(16'hF200, 16'h0000);
        #1;
        check("busy command", {31'h0, protocol_err}, 32'h1);
        h.rd_reg(cpid_pkg::ADDR_STATUS, d);
        check("busy status", d, {16'h0000, v[15:8], 8'h16});
        h.poll(d);
        check("busy end", d, 32'h0000_0802);
        $display("test busy command done");
        tally_and_finish();
    end
endmodule : coprocessor_instruction_dialog_tb

`default_nettype wire
